/* hw/gtc_pkg.sv */
// Package of constants and types for the general timer counter core.
package gtc_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] GTC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] GTC_OFF_SMCFG  = 8'h08;
	localparam logic [7:0] GTC_OFF_STATUS = 8'h10;
	localparam logic [7:0] GTC_OFF_SWEV   = 8'h14;
	localparam logic [7:0] GTC_OFF_CNT    = 8'h24;
	localparam logic [7:0] GTC_OFF_PSC    = 8'h28;
	localparam logic [7:0] GTC_OFF_CAR    = 8'h2C;
	// ==========================================================
	// Field positions
	localparam int GTC_CTRL_CEN   = 0;
	localparam int GTC_CTRL_UPDATE_DISABLE = 1;
	localparam int GTC_CTRL_DIR   = 4;
	localparam int GTC_CTRL_CAM   = 5;
	localparam int GTC_CTRL_RELOAD_SHADOW_ENABLE  = 7;
	localparam int GTC_SM_SMC     = 0;
	localparam int GTC_SM_TRIGGER_SELECT    = 4;
	localparam int GTC_SM_FLT     = 8;
	localparam int GTC_SM_POL     = 12;
	localparam int GTC_SM_EXTERNAL_CLOCK_MODE1_ENABLE    = 14;
	localparam int GTC_ST_UPF     = 0;
	localparam int GTC_SW_UPG     = 0;
	// ==========================================================
	// Encodings and reset values
	localparam logic [2:0] GTC_SMC_INT  = 3'h0;
	localparam logic [2:0] GTC_SMC_EXT0 = 3'h7;
	localparam logic [2:0] GTC_TRG_CI0A = 3'h4;
	localparam logic [2:0] GTC_TRG_CI0  = 3'h5;
	localparam logic [2:0] GTC_TRG_CI1  = 3'h6;
	localparam logic [2:0] GTC_TRG_ETI  = 3'h7;
	localparam logic [1:0] GTC_CAM_EDGE = 2'h0;
	localparam logic [15:0] GTC_RST_CAR = 16'hFFFF;
	localparam logic [15:0] GTC_RST_ZERO = 16'h0000;
	localparam logic [15:0] GTC_ONE16    = 16'h0001;

	typedef struct packed {
		logic       reloadShadowEnable;
		logic [1:0] alignMode;
		logic       direction;
		logic       updateDisable;
		logic       counterEnable;
	} gtc_ctrl_t;

	typedef struct packed {
		logic       externalClockMode1Enable;
		logic       edgeFalling;
		logic [3:0] filterLength;
		logic [2:0] triggerSelect;
		logic [2:0] slaveModeSelect;
	} gtc_smcfg_t;
endpackage

/* hw/gtc_core.sv */
// General timer counter core with clock selection and a Wishbone slave.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R01 - Counter is an unsigned 16-bit register wrapping within the reload range.
// R02 - Slave mode zero clocks the prescaler from the kernel clock.
// R03 - Slave modes four, five and six also use the kernel clock.
// R04 - Slave modes one, two, three and seven use the trigger-selected source.
// R05 - Mode seven, trigger four to six: count channel input zero or one edges.
// R06 - Mode seven, trigger zero to three: count internal trigger rising edges.
// R07 - External clock mode 1 set: count edges of the external trigger pin.
// R08 - Mode seven with trigger seven also selects the external trigger.
// R09 - External trigger is filtered; one pulse per filtered rising edge.
// R10 - Prescaler divides by value plus one, range 1 to 65536.
// R11 - New prescaler value is held and applied at the next update.
// R12 - Counter clock pulses occur only while counter enable is set.
// R13 - Up mode counts 0 to reload, restarts at 0, update on overflow.
// R14 - Software writes direction 0 to select up counting.
// R15 - Update generate in up mode clears the counter and updates.
// R16 - Down mode counts reload to 0, reloads, update on underflow.
// R17 - Software writes direction 1 to select down counting.
// R18 - Update generate in down mode loads the reload value and updates.
// R19 - Update disable suppresses all update events.
// R20 - Every update copies pending reload and prescaler into active shadows.
// R21 - Center mode alternates up and down; direction read-only there.
// R22 - Reload shadow clear: reload acts at once; set: at next update.
// R23 - Update flag set by hardware on each update, cleared by software.
module gtc_core
	import gtc_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int ADR_W = 8
) (
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	input  wire logic               clkEn,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic               external_trigger_input,
	input  wire logic               channel_input_zero,
	input  wire logic               channel_input_one,
	input  wire logic [3:0]         internal_trigger_input,
	output logic      [CNT_W-1:0]   counterValue,
	output logic                    updateEvent,
	output logic                    countingDown
);
	initial begin
		if (CNT_W != 16) begin
			$error("gtc_core supports only a 16-bit counter");
		end
		if (ADR_W < 8) begin
			$error("gtc_core needs at least 8 address bits");
		end
	end

	// ==========================================================
	// Register state
	gtc_ctrl_t        ctrl;
	gtc_smcfg_t       smcfg;
	logic             update_flag;
	logic [15:0]      prescaler_value;
	logic [15:0]      pscActive;
	logic [15:0]      pscCount;
	logic [15:0]      counter_reload_value;
	logic [15:0]      carShadow;
	logic [15:0]      cnt;
	logic             downFlag;

	logic             busReq;
	logic             wrReq;
	logic [7:0]       regAdr;
	logic             update_generate;
	logic             upEventRaw;
	logic             updateNow;
	logic             counter_clock;
	logic             prescaler_input_clock;
	logic [15:0]      carEff;
	logic             centerMode;

	assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrReq = busReq & wb_we_i;
	assign regAdr = wb_adr_i[7:0];
	assign update_generate = wrReq & (regAdr == GTC_OFF_SWEV) & wb_sel_i[0]
		& wb_dat_i[GTC_SW_UPG];

	function automatic logic [15:0] mergeLow(
		input logic [15:0] oldVal,
		input logic [31:0] newVal,
		input logic [3:0]  sel
	);
		logic [15:0] r;
		r = oldVal;
		if (sel[0]) begin
			r[7:0] = newVal[7:0];
		end
		if (sel[1]) begin
			r[15:8] = newVal[15:8];
		end
		return r;
	endfunction

	// ==========================================================
	// Pin synchronisers and external trigger filter
	logic [2:0] pinSync1;
	logic [2:0] pinSync2;
	logic [2:0] pinPrev;
	logic [3:0] fltCount;
	logic       etiFilt;
	logic       etiFiltPrev;
	logic [3:0] itiPrev;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinSync1 <= 3'h0;
			pinSync2 <= 3'h0;
		end else if (clkEn) begin
			pinSync1 <= {channel_input_one, channel_input_zero,
				external_trigger_input};
			pinSync2 <= pinSync1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinPrev <= 3'h0;
			itiPrev <= 4'h0;
			etiFiltPrev <= 1'b0;
		end else if (clkEn) begin
			pinPrev <= pinSync2;
			itiPrev <= internal_trigger_input;
			etiFiltPrev <= etiFilt;
		end
	end

	// A level must hold for filterLength extra samples before it passes.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fltCount <= 4'h0;
			etiFilt <= 1'b0;
		end else if (clkEn) begin
			if (pinSync2[0] == etiFilt) begin
				fltCount <= 4'h0;
			end else if (fltCount >= smcfg.filterLength) begin
				etiFilt <= pinSync2[0]; // [R09]
				fltCount <= 4'h0;
			end else begin
				fltCount <= fltCount + 4'h1;
			end
		end
	end

	// ==========================================================
	// Clock source selection
	logic       etiRise;
	logic       ci0Any;
	logic       ci0Edge;
	logic       ci1Edge;
	logic [3:0] itiRise;
	logic       extSel;
	logic       trgTick;

	assign etiRise = etiFilt & ~etiFiltPrev; // [R09]
	assign ci0Any = pinSync2[1] ^ pinPrev[1];
	assign ci0Edge = smcfg.edgeFalling ? (pinPrev[1] & ~pinSync2[1])
		: (pinSync2[1] & ~pinPrev[1]);
	assign ci1Edge = smcfg.edgeFalling ? (pinPrev[2] & ~pinSync2[2])
		: (pinSync2[2] & ~pinPrev[2]);
	assign itiRise = internal_trigger_input & ~itiPrev;

	always_comb begin
		extSel = 1'b0;
		unique case (smcfg.slaveModeSelect)
			GTC_SMC_INT: extSel = 1'b0; // [R02]
			3'h1, 3'h2, 3'h3, GTC_SMC_EXT0: extSel = 1'b1; // [R04]
			3'h4, 3'h5, 3'h6: extSel = 1'b0; // [R03]
		endcase
	end

	always_comb begin
		trgTick = 1'b0;
		unique case (smcfg.triggerSelect)
			3'h0, 3'h1, 3'h2, 3'h3:
				trgTick = itiRise[smcfg.triggerSelect[1:0]]; // [R06]
			GTC_TRG_CI0A: trgTick = ci0Any; // [R05]
			GTC_TRG_CI0: trgTick = ci0Edge; // [R05]
			GTC_TRG_CI1: trgTick = ci1Edge; // [R05]
			GTC_TRG_ETI: trgTick = etiRise; // [R08]
		endcase
	end

	always_comb begin
		if (smcfg.externalClockMode1Enable) begin
			prescaler_input_clock = etiRise; // [R07]
		end else if (extSel) begin
			prescaler_input_clock = trgTick; // [R04]
		end else begin
			prescaler_input_clock = 1'b1; // [R02] [R03]
		end
	end

	// ==========================================================
	// Prescaler
	assign counter_clock = ctrl.counterEnable & prescaler_input_clock
		& (pscCount == pscActive); // [R10] [R12]

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pscCount <= GTC_RST_ZERO;
		end else if (clkEn) begin
			if (updateNow) begin
				pscCount <= GTC_RST_ZERO;
			end else if (ctrl.counterEnable & prescaler_input_clock) begin
				pscCount <= counter_clock ? GTC_RST_ZERO
					: pscCount + GTC_ONE16; // [R10]
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pscActive <= GTC_RST_ZERO;
		end else if (clkEn && updateNow) begin
			pscActive <= prescaler_value; // [R11] [R20]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			carShadow <= GTC_RST_CAR;
		end else if (clkEn && updateNow) begin
			carShadow <= counter_reload_value; // [R20]
		end
	end

	// Without shadowing the written value steers the counter at once.
	assign carEff = ctrl.reloadShadowEnable ? carShadow
		: counter_reload_value; // [R22]
	assign centerMode = ctrl.alignMode != GTC_CAM_EDGE;

	// ==========================================================
	// Counter
	always_comb begin
		upEventRaw = 1'b0;
		if (counter_clock) begin
			if (centerMode) begin
				upEventRaw = downFlag ? (cnt == GTC_ONE16)
					: (cnt == carEff - GTC_ONE16); // [R21]
			end else if (ctrl.direction) begin
				upEventRaw = cnt == GTC_RST_ZERO; // [R16]
			end else begin
				upEventRaw = cnt >= carEff; // [R13]
			end
		end
	end

	assign updateNow = ~ctrl.updateDisable
		& (upEventRaw | update_generate); // [R19]

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= GTC_RST_ZERO;
			downFlag <= 1'b0;
		end else if (clkEn) begin
			if (update_generate) begin
				if (!centerMode && ctrl.direction) begin
					cnt <= carEff; // [R18]
				end else begin
					cnt <= GTC_RST_ZERO; // [R15] [R21]
				end
			end else if (counter_clock) begin
				if (centerMode) begin
					if (downFlag) begin
						cnt <= cnt - GTC_ONE16; // [R21]
						downFlag <= cnt != GTC_ONE16;
					end else begin
						cnt <= cnt + GTC_ONE16; // [R21]
						downFlag <= cnt == carEff - GTC_ONE16;
					end
				end else if (ctrl.direction) begin
					downFlag <= 1'b1;
					cnt <= (cnt == GTC_RST_ZERO) ? carEff
						: cnt - GTC_ONE16; // [R16] [R17]
				end else begin
					downFlag <= 1'b0;
					cnt <= (cnt >= carEff) ? GTC_RST_ZERO
						: cnt + GTC_ONE16; // [R01] [R13] [R14]
				end
			end else if (wrReq && regAdr == GTC_OFF_CNT) begin
				cnt <= mergeLow(cnt, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= '0;
			smcfg <= '0;
		end else if (clkEn && wrReq) begin
			if (regAdr == GTC_OFF_CTRL && wb_sel_i[0]) begin
				ctrl.counterEnable <= wb_dat_i[GTC_CTRL_CEN];
				ctrl.updateDisable <= wb_dat_i[GTC_CTRL_UPDATE_DISABLE];
				ctrl.direction <= wb_dat_i[GTC_CTRL_DIR];
				ctrl.alignMode <= wb_dat_i[GTC_CTRL_CAM +: 2];
				ctrl.reloadShadowEnable <= wb_dat_i[GTC_CTRL_RELOAD_SHADOW_ENABLE];
			end
			if (regAdr == GTC_OFF_SMCFG && wb_sel_i[0]) begin
				smcfg.slaveModeSelect <= wb_dat_i[GTC_SM_SMC +: 3];
				smcfg.triggerSelect <= wb_dat_i[GTC_SM_TRIGGER_SELECT +: 3];
			end
			if (regAdr == GTC_OFF_SMCFG && wb_sel_i[1]) begin
				smcfg.filterLength <= wb_dat_i[GTC_SM_FLT +: 4];
				smcfg.edgeFalling <= wb_dat_i[GTC_SM_POL];
				smcfg.externalClockMode1Enable <= wb_dat_i[GTC_SM_EXTERNAL_CLOCK_MODE1_ENABLE];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prescaler_value <= GTC_RST_ZERO;
			counter_reload_value <= GTC_RST_CAR;
		end else if (clkEn && wrReq) begin
			if (regAdr == GTC_OFF_PSC) begin
				prescaler_value <= mergeLow(prescaler_value, wb_dat_i,
					wb_sel_i); // [R11]
			end
			if (regAdr == GTC_OFF_CAR) begin
				counter_reload_value <= mergeLow(counter_reload_value,
					wb_dat_i, wb_sel_i); // [R22]
			end
		end
	end

	// An update in the same cycle as a clearing write keeps the flag set.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			update_flag <= 1'b0;
		end else if (clkEn) begin
			if (updateNow) begin
				update_flag <= 1'b1; // [R23]
			end else if (wrReq && regAdr == GTC_OFF_STATUS && wb_sel_i[0]
					&& !wb_dat_i[GTC_ST_UPF]) begin
				update_flag <= 1'b0; // [R23]
			end
		end
	end

	// ==========================================================
	// Wishbone answer
	logic [31:0] next_rdData;

	always_comb begin
		next_rdData = 32'h0000_0000;
		unique case (regAdr)
			GTC_OFF_CTRL: begin
				next_rdData[GTC_CTRL_CEN] = ctrl.counterEnable;
				next_rdData[GTC_CTRL_UPDATE_DISABLE] = ctrl.updateDisable;
				next_rdData[GTC_CTRL_DIR] = centerMode ? downFlag
					: ctrl.direction; // [R21]
				next_rdData[GTC_CTRL_CAM +: 2] = ctrl.alignMode;
				next_rdData[GTC_CTRL_RELOAD_SHADOW_ENABLE] = ctrl.reloadShadowEnable;
			end
			GTC_OFF_SMCFG: begin
				next_rdData[GTC_SM_SMC +: 3] = smcfg.slaveModeSelect;
				next_rdData[GTC_SM_TRIGGER_SELECT +: 3] = smcfg.triggerSelect;
				next_rdData[GTC_SM_FLT +: 4] = smcfg.filterLength;
				next_rdData[GTC_SM_POL] = smcfg.edgeFalling;
				next_rdData[GTC_SM_EXTERNAL_CLOCK_MODE1_ENABLE] = smcfg.externalClockMode1Enable;
			end
			GTC_OFF_STATUS: next_rdData[GTC_ST_UPF] = update_flag;
			GTC_OFF_CNT: next_rdData[15:0] = cnt;
			GTC_OFF_PSC: next_rdData[15:0] = prescaler_value;
			GTC_OFF_CAR: next_rdData[15:0] = counter_reload_value;
			default: next_rdData = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clkEn) begin
			wb_ack_o <= busReq;
			if (busReq && !wb_we_i) begin
				wb_dat_o <= next_rdData;
			end
		end
	end

	// ==========================================================
	// Status outputs
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			updateEvent <= 1'b0;
		end else if (clkEn) begin
			updateEvent <= updateNow;
		end
	end

	assign counterValue = cnt;
	assign countingDown = downFlag;
endmodule

`default_nettype wire

/* tb/gtc_core_assertions.sv */
// Concurrent checks on the ports of the timer counter core.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker
module gtc_core_checker
	import gtc_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int ADR_W = 8
) (
	input wire logic		ref_clk,
	input wire logic		rstn,
	input wire logic		clkEn,
	input wire logic		wb_cyc_i,
	input wire logic		wb_stb_i,
	input wire logic		wb_we_i,
	input wire logic [31:0]		wb_dat_o,
	input wire logic		wb_ack_o,
	input wire logic [CNT_W-1:0]	counterValue,
	input wire logic		updateEvent,
	input wire logic		countingDown
);
	logic	wrReq;
	assign wrReq = wb_cyc_i && wb_stb_i && wb_we_i;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	ack_follows_a:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
		else $error("ack missing");
	ack_pulse_a:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a:
	assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	state_freeze_a:
	assert property (!clkEn |=> $stable(counterValue) && $stable(wb_ack_o))
		else $error("state moved while frozen");
	up_step_a:
	assert property (!countingDown && !$past(countingDown) && !$past(wrReq)
		&& counterValue != $past(counterValue) |-> counterValue == '0
		|| counterValue == CNT_W'($past(counterValue) + 1))
		else $error("bad up step");
	down_step_a:
	assert property (countingDown && $past(countingDown) && !$past(wrReq)
		&& counterValue != $past(counterValue) |-> $past(counterValue) == '0
		|| counterValue == CNT_W'($past(counterValue) - 1))
		else $error("bad down step");
	upper_zero_a:
	assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	reset_clear_a:
	assert property ($rose(rstn) |-> counterValue == '0 && !updateEvent)
		else $error("reset values wrong");
	update_cause_a:
	assert property (updateEvent |-> counterValue == '0
		|| countingDown || $past(wrReq))
		else $error("update without cause");
endmodule
bind gtc_core gtc_core_checker #(.CNT_W(CNT_W), .ADR_W(ADR_W)) chk_i (
	.ref_clk, .rstn, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
	.wb_ack_o, .counterValue, .updateEvent, .countingDown);
`default_nettype wire

/* tb/gtc_pin_model.sv */
// Model of the pins and trigger sources that drive the timer core.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Pin drivers
module gtc_pin_model (
	input  wire logic	ref_clk,
	output logic		external_trigger_input,
	output logic		channel_input_zero,
	output logic		channel_input_one,
	output logic [3:0]	internal_trigger_input
);
	logic [6:0]	pins = 7'h00;
	assign {external_trigger_input, channel_input_one, channel_input_zero,
		internal_trigger_input} = pins;
	// Pulses last four cycles so synchronisers and the shortest filter pass them.
	task automatic emit(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			pins[idx] <= 1'b1;
			repeat (4) @(posedge ref_clk);
			pins[idx] <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

/* tb/general_timer_counter_core_test.sv */
// Self-checking bench for the timer counter core.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench top
module general_timer_counter_core_test;
	import gtc_pkg::*;
	logic		ref_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1;
	logic		wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]	wb_adr_i = 8'h00;
	logic [3:0]	wb_sel_i = 4'hF, internal_trigger_input;
	logic [31:0]	wb_dat_i = 32'h0, wb_dat_o, q;
	logic		wb_ack_o, updateEvent, countingDown;
	logic		external_trigger_input, channel_input_zero, channel_input_one;
	logic [15:0]	counterValue;
	int		n_mismatch = 0, checked = 0, cycles = 0, n, per;
	int		seed = 32'hD63CE3DB;
	logic [15:0]	cfg [9] = '{16'h0007, 16'h0017, 16'h0027, 16'h0037,
		16'h0047, 16'h0057, 16'h0067, 16'h0077, 16'h4000};
	int		pin [9] = '{0, 1, 2, 3, 4, 4, 5, 6, 6};
	int		mul [9] = '{1, 1, 1, 1, 2, 1, 1, 1, 1};
	gtc_core gtc_core_i (.ref_clk, .rstn, .clkEn, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.external_trigger_input, .channel_input_zero, .channel_input_one,
		.internal_trigger_input, .counterValue, .updateEvent, .countingDown);
	gtc_pin_model gtc_pin_model_i (.ref_clk, .external_trigger_input,
		.channel_input_zero, .channel_input_one, .internal_trigger_input);
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Ack is sampled at the rising edge; data is taken and the request
	// released at that same edge.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		acc(1'b0, a, 32'h0);
	endtask
	task automatic period(output int p);
		logic [15:0] v;
		@(negedge ref_clk);
		v = counterValue;
		while (counterValue === v) @(negedge ref_clk);
		v = counterValue;
		p = 0;
		while (counterValue === v) begin
			@(negedge ref_clk);
			p++;
		end
	endtask
	task automatic wait_val(input logic [15:0] v);
		while (counterValue !== v) @(negedge ref_clk);
	endtask
	task automatic tally_and_finish;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(GTC_OFF_CAR);
		check(q, 32'h0000FFFF);
		rd(GTC_OFF_PSC);
		check(q, 32'h0);
		rd(8'h40);
		check(q, 32'h0);
		$display("reset test done");
		wr(GTC_OFF_CAR, 32'h5);
		wr(GTC_OFF_PSC, 32'h2);
		wr(GTC_OFF_SWEV, 32'h1);
		wr(GTC_OFF_CTRL, 32'h1);
		period(per);
		check(per, 3);
		wr(GTC_OFF_PSC, 32'h0);
		period(per);
		check(per, 3);
		wait_val(16'h0005);
		wait_val(16'h0000);
		check(updateEvent, 1'b1);
		period(per);
		check(per, 1);
		rd(GTC_OFF_STATUS);
		check(q[0], 1'b1);
		$display("up count test done");
		wr(GTC_OFF_CTRL, 32'h0);
		n = $random(seed);
		wr(GTC_OFF_CNT, n & 32'hFFFF);
		wr(GTC_OFF_SWEV, 32'h1);
		rd(GTC_OFF_CNT);
		check(q, 32'h0);
		wr(GTC_OFF_STATUS, 32'h0);
		rd(GTC_OFF_STATUS);
		check(q[0], 1'b0);
		wr(GTC_OFF_CTRL, 32'h10);
		wr(GTC_OFF_SWEV, 32'h1);
		rd(GTC_OFF_CNT);
		check(q, 32'h5);
		wr(GTC_OFF_CTRL, 32'h11);
		@(negedge ref_clk);
		check(countingDown, 1'b1);
		wait_val(16'h0000);
		wait_val(16'h0005);
		check(updateEvent, 1'b1);
		$display("down count test done");
		wr(GTC_OFF_CTRL, 32'h2);
		wr(GTC_OFF_STATUS, 32'h0);
		wr(GTC_OFF_SWEV, 32'h1);
		rd(GTC_OFF_STATUS);
		check(q[0], 1'b0);
		clkEn <= 1'b0;
		repeat (5) @(posedge ref_clk);
		clkEn <= 1'b1;
		repeat (20) @(negedge ref_clk);
		check(counterValue, 16'h0000);
		$display("disable test done");
		wr(GTC_OFF_CAR, 32'hFF);
		for (int i = 0; i < 9; i++) begin
			wr(GTC_OFF_CTRL, 32'h0);
			wr(GTC_OFF_CNT, 32'h0);
			wr(GTC_OFF_SMCFG, {16'h0, cfg[i]});
			wr(GTC_OFF_CTRL, 32'h1);
			n = 1 + ($random(seed) & 3);
			gtc_pin_model_i.emit(pin[i], n);
			repeat (8) @(posedge ref_clk);
			rd(GTC_OFF_CNT);
			check(q, 32'(n * mul[i]));
		end
		wr(GTC_OFF_SMCFG, 32'h4);
		period(per);
		check(per, 1);
		$display("clock source test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
